/* File: pkg/usr_defs.svh */
`ifndef USR_DEFS_SVH
`define USR_DEFS_SVH

// Width of the storage word and its end bit positions.
`define USR_BITS       8
`define USR_MSB        7
`define USR_LSB        0
`define USR_STORE_RST  8'h00

// Released level of the active-low pins while the synchroniser resets.
`define USR_PIN_IDLE_N 1'h1

// Register byte offsets on the AXI4-Lite slave.
`define USR_OFS_CTRL   32'h0000_0000
`define USR_OFS_STATUS 32'h0000_0004
`define USR_OFS_COUNT  32'h0000_0008

// Field layout of the control and status words.
`define USR_CTRL_STEP  0
`define USR_CTRL_PAD   31
`define USR_ST_PAD     20

// Reset and step values of the event counter.
`define USR_COUNT_RST  32'h0000_0000
`define USR_COUNT_INC  32'h0000_0001
`define USR_WORD_RST   32'h0000_0000

// AXI response codes.
`define USR_RESP_OKAY  2'h0
`define USR_RESP_SLVERR 2'h2

`endif

/* File: pkg/usr_pkg.sv */
`include "usr_defs.svh"

package usr_pkg;

	// Operation chosen by {mode_select_high, mode_select_low}.
	typedef enum logic [1:0] {
		USR_MODE_HOLD  = 2'h0,
		USR_MODE_RIGHT = 2'h1,
		USR_MODE_LEFT  = 2'h2,
		USR_MODE_LOAD  = 2'h3
	} usr_mode_t;

	// Register selected by a bus address.
	typedef enum logic [1:0] {
		USR_REG_NONE   = 2'h0,
		USR_REG_CTRL   = 2'h1,
		USR_REG_STATUS = 2'h3,
		USR_REG_COUNT  = 2'h2
	} usr_reg_t;

	// All pin inputs that cross into the aclk domain.
	typedef struct packed {
		logic                 clock_pulse;
		logic                 right_shift_serial_in;
		logic                 left_shift_serial_in;
		usr_mode_t            mode;
		logic                 sync_clear_n;
		logic                 bus_drive_enable_a_n;
		logic                 bus_drive_enable_b_n;
		logic [`USR_MSB:0]    bus_in;
	} usr_pins_t;

	// State of the pin synchroniser.
	typedef struct packed {
		usr_pins_t stage_one;
		usr_pins_t stage_two;
	} usr_sync_state_t;

	// State of the shift register and its bus slave.
	typedef struct packed {
		logic [`USR_MSB:0] storage;
		logic              bus_oe;
		logic              clk_prev;
		logic              step_pend;
		logic [31:0]       count;
		logic              aw_held;
		logic [31:0]       aw_addr;
		logic              w_held;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} usr_state_t;

endpackage

/* File: src/usr_sync.sv */
`include "usr_defs.svh"

module usr_sync (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire usr_pkg::usr_pins_t pins_raw,
	output usr_pkg::usr_pins_t      pins_sync
);

	usr_pkg::usr_sync_state_t st;
	usr_pkg::usr_sync_state_t next_st;
	usr_pkg::usr_sync_state_t idle_st;

	// Enables and clear rest released, so reset never turns the drivers on.
	always_comb begin
		idle_st = '0;
		idle_st.stage_one.sync_clear_n = `USR_PIN_IDLE_N;
		idle_st.stage_one.bus_drive_enable_a_n = `USR_PIN_IDLE_N;
		idle_st.stage_one.bus_drive_enable_b_n = `USR_PIN_IDLE_N;
		idle_st.stage_two.sync_clear_n = `USR_PIN_IDLE_N;
		idle_st.stage_two.bus_drive_enable_a_n = `USR_PIN_IDLE_N;
		idle_st.stage_two.bus_drive_enable_b_n = `USR_PIN_IDLE_N;
	end

	// The first stage feeds only the second stage.
	always_comb begin
		next_st = st;
		next_st.stage_one = pins_raw;
		next_st.stage_two = st.stage_one;
	end

	// Both stages return to the idle pin levels under the synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= idle_st;
		end else begin
			st <= next_st;
		end
	end

	assign pins_sync = st.stage_two;

endmodule

/* File: src/usr_top.sv */
// Functional notes
// - Eight D storage bits, operation per clock.
// - Mode selects choose hold, right, left, load.
// - Low clear zeroes all bits, overrides mode.
// - State changes only on clock rising edge; a software step through the control register also changes it.
// - Either enable high releases all bus pins.
// - Operations continue while bus is released.
// - Load mode releases bus regardless of enables.
// - Load mode captures bus pins into storage.
// - Right shift takes serial in at bit 0.
// - Left shift takes serial in at bit 7.
// - Both selects low keep storage unchanged.
// - Bits 0 and 7 on own serial outputs.
// - Bus pins are load inputs or driven outputs.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`include "usr_defs.svh"

module usr_top (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              clock_pulse,
	input  wire logic              right_shift_serial_in,
	input  wire logic              left_shift_serial_in,
	input  wire logic              mode_select_low,
	input  wire logic              mode_select_high,
	input  wire logic              sync_clear_n,
	input  wire logic              bus_drive_enable_a_n,
	input  wire logic              bus_drive_enable_b_n,
	input  wire logic [`USR_MSB:0] parallel_bus_in,
	output logic      [`USR_MSB:0] parallel_bus_out,
	output logic      [`USR_MSB:0] parallel_bus_oe,
	output logic                   serial_out_bit_zero,
	output logic                   serial_out_bit_seven,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	usr_pkg::usr_pins_t  pins_raw;
	usr_pkg::usr_pins_t  pins_s;
	usr_pkg::usr_state_t st;
	usr_pkg::usr_state_t next_st;

	logic                ev;
	logic                have_aw;
	logic                have_w;
	logic                wr_do;
	logic [31:0]         wr_addr;
	logic [31:0]         wr_data;
	logic [3:0]          wr_strb;
	logic [`USR_MSB:0]   bus_in_s;
	logic                clr_n_s;
	logic                rsi_s;
	logic                lsi_s;
	usr_pkg::usr_mode_t  mode_s;

	// Maps a byte address onto one of the registers.
	function automatic usr_pkg::usr_reg_t usr_decode(
		input logic [31:0] addr
	);
		usr_pkg::usr_reg_t r;
		r = usr_pkg::USR_REG_NONE;
		case (addr)
			`USR_OFS_CTRL:   r = usr_pkg::USR_REG_CTRL;
			`USR_OFS_STATUS: r = usr_pkg::USR_REG_STATUS;
			`USR_OFS_COUNT:  r = usr_pkg::USR_REG_COUNT;
			default:         r = usr_pkg::USR_REG_NONE;
		endcase
		return r;
	endfunction

	// Gathers the pins that arrive from outside the aclk domain.
	always_comb begin
		pins_raw = '0;
		pins_raw.clock_pulse = clock_pulse;
		pins_raw.right_shift_serial_in = right_shift_serial_in;
		pins_raw.left_shift_serial_in = left_shift_serial_in;
		pins_raw.mode = usr_pkg::usr_mode_t'({mode_select_high,
			mode_select_low});
		pins_raw.sync_clear_n = sync_clear_n;
		pins_raw.bus_drive_enable_a_n = bus_drive_enable_a_n;
		pins_raw.bus_drive_enable_b_n = bus_drive_enable_b_n;
		pins_raw.bus_in = parallel_bus_in;
	end

	// Every pin passes two flip-flops before any logic reads it.
	usr_sync u_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pins_raw  (pins_raw),
		.pins_sync (pins_s)
	);

	// Short names for the synchronised pins.
	assign bus_in_s = pins_s.bus_in;
	assign clr_n_s  = pins_s.sync_clear_n;
	assign rsi_s    = pins_s.right_shift_serial_in;
	assign lsi_s    = pins_s.left_shift_serial_in;
	assign mode_s   = pins_s.mode;

	// A rising edge of the clock pin, or a software step, is one event.
	assign ev = (pins_s.clock_pulse & ~st.clk_prev) | st.step_pend;

	// Write address and data may arrive in either order.
	assign have_aw = st.aw_held | s_axi_awvalid;
	assign have_w  = st.w_held | s_axi_wvalid;
	assign wr_do   = have_aw & have_w & ~st.bvalid;
	assign wr_addr = st.aw_held ? st.aw_addr : s_axi_awaddr;
	assign wr_data = st.w_held ? st.w_data : s_axi_wdata;
	assign wr_strb = st.w_held ? st.w_strb : s_axi_wstrb;

	// Handshake outputs follow the state directly.
	assign s_axi_awready = ~st.aw_held & ~st.bvalid;
	assign s_axi_wready  = ~st.w_held & ~st.bvalid;
	assign s_axi_arready = ~st.rvalid;

	// Next state of the storage bits, the bus drivers and the slave.
	always_comb begin
		next_st = st;
		next_st.clk_prev = pins_s.clock_pulse;
		next_st.step_pend = 1'h0;

		// The storage bits move only on an event, whatever the drivers do.
		if (ev) begin
			next_st.count = st.count + `USR_COUNT_INC;
			if (!clr_n_s) begin
				next_st.storage = `USR_STORE_RST;
			end else begin
				case (mode_s)
					usr_pkg::USR_MODE_HOLD: begin
						next_st.storage = st.storage;
					end
					usr_pkg::USR_MODE_RIGHT: begin
						next_st.storage = {st.storage[`USR_MSB-1:`USR_LSB],
							rsi_s};
					end
					usr_pkg::USR_MODE_LEFT: begin
						next_st.storage = {lsi_s,
							st.storage[`USR_MSB:`USR_LSB+1]};
					end
					usr_pkg::USR_MODE_LOAD: begin
						next_st.storage = bus_in_s;
					end
					default: begin
						next_st.storage = st.storage;
					end
				endcase
			end
		end

		// Drivers are on only with both enables low and load mode off.
		next_st.bus_oe = ~(pins_s.bus_drive_enable_a_n |
			pins_s.bus_drive_enable_b_n) &
			(mode_s != usr_pkg::USR_MODE_LOAD);

		// A write completes once address and data are both present.
		if (wr_do) begin
			next_st.aw_held = 1'h0;
			next_st.w_held = 1'h0;
			next_st.bvalid = 1'h1;
			if (usr_decode(wr_addr) == usr_pkg::USR_REG_CTRL) begin
				next_st.bresp = `USR_RESP_OKAY;
				if (wr_strb[0] && wr_data[`USR_CTRL_STEP]) begin
					next_st.step_pend = 1'h1;
				end
			end else begin
				next_st.bresp = `USR_RESP_SLVERR;
			end
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				next_st.aw_held = 1'h1;
				next_st.aw_addr = s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				next_st.w_held = 1'h1;
				next_st.w_data = s_axi_wdata;
				next_st.w_strb = s_axi_wstrb;
			end
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'h0;
		end

		// A read answers in the cycle after its address is taken.
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rvalid = 1'h1;
			next_st.rresp = `USR_RESP_OKAY;
			case (usr_decode(s_axi_araddr))
				usr_pkg::USR_REG_CTRL: begin
					next_st.rdata = {{`USR_CTRL_PAD{1'h0}},
						st.step_pend};
				end
				usr_pkg::USR_REG_STATUS: begin
					next_st.rdata = {{`USR_ST_PAD{1'h0}}, st.bus_oe,
						clr_n_s, mode_s, st.storage};
				end
				usr_pkg::USR_REG_COUNT: begin
					next_st.rdata = st.count;
				end
				default: begin
					next_st.rdata = `USR_WORD_RST;
					next_st.rresp = `USR_RESP_SLVERR;
				end
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'h0;
		end
	end

	// All state clears under the synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Parallel data and drive enables come straight from flip-flops.
	assign parallel_bus_out = st.storage;
	assign parallel_bus_oe  = {`USR_BITS{st.bus_oe}};

	// End bits are always driven for cascading.
	assign serial_out_bit_zero  = st.storage[`USR_LSB];
	assign serial_out_bit_seven = st.storage[`USR_MSB];

	// Bus answers.
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp  = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp  = st.rresp;
	assign s_axi_rdata  = st.rdata;

	// Checks on the storage behaviour and the bus slave.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Clear overrides every mode.
	a_clear_wins: assert property (
		ev && !clr_n_s |=> st.storage == `USR_STORE_RST)
		else $error("Clear did not zero the storage bits.");

	// Without an event the storage never moves.
	a_edge_only: assert property (
		!ev |=> $stable(st.storage))
		else $error("Storage changed without a clock event.");

	// Hold mode keeps the word.
	a_hold_mode: assert property (
		ev && clr_n_s && mode_s == usr_pkg::USR_MODE_HOLD
		|=> $stable(st.storage))
		else $error("Hold mode changed the storage bits.");

	// Load copies the synchronised bus.
	a_load_bus: assert property (
		ev && clr_n_s && mode_s == usr_pkg::USR_MODE_LOAD
		|=> st.storage == $past(bus_in_s))
		else $error("Load did not capture the bus.");

	// Right shift moves bits up and takes the serial input.
	a_shift_right: assert property (
		ev && clr_n_s && mode_s == usr_pkg::USR_MODE_RIGHT
		|=> st.storage == {$past(st.storage[`USR_MSB-1:`USR_LSB]),
			$past(rsi_s)})
		else $error("Right shift produced a wrong word.");

	// Left shift moves bits down and takes the serial input.
	a_shift_left: assert property (
		ev && clr_n_s && mode_s == usr_pkg::USR_MODE_LEFT
		|=> st.storage == {$past(lsi_s),
			$past(st.storage[`USR_MSB:`USR_LSB+1])})
		else $error("Left shift produced a wrong word.");

	// Either enable high releases the bus.
	a_enable_off: assert property (
		pins_s.bus_drive_enable_a_n || pins_s.bus_drive_enable_b_n
		|=> parallel_bus_oe == '0)
		else $error("Bus driven with an enable high.");

	// Load mode releases the bus.
	a_load_off: assert property (
		mode_s == usr_pkg::USR_MODE_LOAD |=> parallel_bus_oe == '0)
		else $error("Bus driven in load mode.");

	// Otherwise all pins drive the storage word.
	a_bus_drive: assert property (
		!pins_s.bus_drive_enable_a_n && !pins_s.bus_drive_enable_b_n &&
		mode_s != usr_pkg::USR_MODE_LOAD
		|=> parallel_bus_oe == '1 && parallel_bus_out == st.storage)
		else $error("Bus not driven with the storage word.");

	// A right shift shows the serial input and the old bit 6 at the ends.
	a_serial_ends: assert property (
		ev && clr_n_s && mode_s == usr_pkg::USR_MODE_RIGHT
		|=> serial_out_bit_zero == $past(rsi_s) &&
		serial_out_bit_seven == $past(st.storage[`USR_MSB-1]))
		else $error("Serial outputs differ from the end bits.");

	// Shifting goes on while the bus is released.
	a_released_op: assert property (
		ev && clr_n_s && !st.bus_oe &&
		mode_s == usr_pkg::USR_MODE_RIGHT
		|=> st.storage[`USR_LSB] == $past(rsi_s))
		else $error("Shift lost while bus released.");

	// A completed write answers in the next cycle.
	a_write_resp: assert property (
		wr_do |=> s_axi_bvalid)
		else $error("Write response missing.");

	// A taken read answers in the next cycle.
	a_read_resp: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read response missing.");

	// Main scenarios.
	c_load: cover property (
		ev && clr_n_s && mode_s == usr_pkg::USR_MODE_LOAD);
	c_right: cover property (
		ev && clr_n_s && mode_s == usr_pkg::USR_MODE_RIGHT);
	c_left: cover property (
		ev && clr_n_s && mode_s == usr_pkg::USR_MODE_LEFT);
	c_clear: cover property (ev && !clr_n_s);
	c_step: cover property (st.step_pend);

endmodule

/* File: verif/usr_far_end.sv */
// Far-side logic sharing the parallel bus with the device.
module usr_far_end (
	input  wire logic       aclk,
	input  wire logic [7:0] dev_out,
	input  wire logic [7:0] dev_oe,
	input  wire logic       ext_en,
	input  wire logic [7:0] ext_data,
	output logic      [7:0] wire_level
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] last = 8'h00;

	// Resolves each wire; undriven bits toggle since there is no pull.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (dev_oe[i])
				wire_level[i] = dev_out[i];
			else if (ext_en)
				wire_level[i] = ext_data[i];
			else
				wire_level[i] = ~last[i];
		end
	end

	// Remembers the wire so a floating bit shows its inverse next cycle.
	always_ff @(posedge aclk) begin
		last <= wire_level;
	end
endmodule

/* File: verif/tb_universal_shift_storage_register.sv */
// Random pin and software events against a reference of the register.
module tb_universal_shift_storage_register;
	timeunit 1ns;
	timeprecision 1ns;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        pulse = 1'b0, rsi = 1'b0, lsi = 1'b0, msl = 1'b0;
	logic        msh = 1'b0;
	logic        clr_n = 1'b1, ena_n = 1'b1, enb_n = 1'b1, ext_en = 1'b0;
	logic [7:0]  ext_data = 8'h00, wire_lvl, bus_out, bus_oe, store;
	logic        ser_lo, ser_hi, awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000;
	logic [31:0] araddr = 32'h0000_0000, rdata, events, got;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [1:0]  bresp, rresp, resp, mode;
	integer      seed = 32'hb08cd91d;
	int          fails = 0, tests_run = 0;

	// The system clock at 25 MHz.
	always #20 aclk = ~aclk;

	usr_far_end far (.aclk(aclk), .dev_out(bus_out), .dev_oe(bus_oe),
		.ext_en(ext_en), .ext_data(ext_data), .wire_level(wire_lvl));

	usr_top dut (.aclk(aclk), .aresetn(aresetn), .clock_pulse(pulse),
		.right_shift_serial_in(rsi), .left_shift_serial_in(lsi),
		.mode_select_low(msl), .mode_select_high(msh),
		.sync_clear_n(clr_n), .bus_drive_enable_a_n(ena_n),
		.bus_drive_enable_b_n(enb_n), .parallel_bus_in(wire_lvl),
		.parallel_bus_out(bus_out), .parallel_bus_oe(bus_oe),
		.serial_out_bit_zero(ser_lo), .serial_out_bit_seven(ser_hi),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// Reference of one event on the storage word.
	function automatic logic [7:0] next_store(logic [7:0] s, logic c,
		logic [1:0] m, logic r, logic l, logic [7:0] b);
		if (!c)
			return 8'h00;
		case (m)
			usr_pkg::USR_MODE_RIGHT: return {s[6:0], r};
			usr_pkg::USR_MODE_LEFT:  return {l, s[7:1]};
			usr_pkg::USR_MODE_LOAD:  return b;
			default:                 return s;
		endcase
	endfunction

	// Compares one value and counts the result.
	task automatic check(input logic [31:0] g, input logic [31:0] e,
		input string what);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, g, e);
		end
	endtask

	// Write with address and data offered together; waits for the answer.
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w, b;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			r = bresp;
			@(posedge aclk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Read of one word; waits for the answer.
	task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar, rv;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ar = arvalid & arready;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar)
				arvalid <= 1'b0;
		end while (!rv);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		complete_run();
	end

	// Main sequence.
	initial begin
		logic [31:0] r;
		logic        drive;
		store = 8'h00;
		events = 32'h0000_0000;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check({ser_hi, ser_lo, bus_oe}, 32'h0000_0000, "reset outputs");
		@(posedge aclk);
		for (int i = 0; i < 48; i++) begin
			r = $random(seed);
			mode = (i < 4) ? i[1:0] : r[6:5];
			msl <= mode[0];
			msh <= mode[1];
			clr_n <= (i == 4) ? 1'b0 : (r[8:7] != 2'b00);
			rsi <= r[0];
			lsi <= r[1];
			ena_n <= (i < 4) ? 1'b0 : r[2];
			enb_n <= (i < 4) ? 1'b0 : r[3];
			ext_en <= (mode == 2'h3);
			ext_data <= r[23:16];
			repeat (4) @(posedge aclk);
			drive = (mode != 2'h3) && !ena_n && !enb_n;
			check(bus_oe, {8{drive}}, "bus enable");
			if (drive)
				check(bus_out, store, "bus data");
			if (r[4]) begin
				axi_write(32'h0000_0000, 32'h0000_0001, resp);
				check(resp, 2'h0, "step resp");
			end else begin
				pulse <= 1'b1;
				repeat (3) @(posedge aclk);
				pulse <= 1'b0;
				repeat (3) @(posedge aclk);
			end
			store = next_store(store, clr_n, mode, rsi, lsi, ext_data);
			events = events + 32'h0000_0001;
			repeat (4) @(posedge aclk);
			check({ser_hi, ser_lo}, {store[7], store[0]}, "serial outs");
			axi_read(32'h0000_0004, got, resp);
			check(got[7:0], store, "storage");
			check(resp, 2'h0, "status resp");
			check(got[11], drive, "status enable");
		end
		axi_read(32'h0000_0008, got, resp);
		check(got, events, "event count");
		axi_read(32'h0000_000c, got, resp);
		check({got, resp}, {32'h0000_0000, 2'h2}, "unmapped read");
		axi_write(32'h0000_0004, 32'h0000_0001, resp);
		check(resp, 2'h2, "read-only write");
		axi_write(32'h0000_0010, 32'h0000_0001, resp);
		check(resp, 2'h2, "unmapped write");
		axi_read(32'h0000_0008, got, resp);
		check(got, events, "count unchanged");
		axi_read(32'h0000_0004, got, resp);
		check(got[7:0], store, "storage unchanged");
		axi_read(32'h0000_0000, got, resp);
		check({got, resp}, {32'h0000_0000, 2'h0}, "control read");
		complete_run();
	end
endmodule
